/* src/flash_cmd_pkg.sv */
// Package for the flash command sequencer: command codes, field layouts, reset values, timing.
// Assumes one 20 MHz core clock and an active-high asynchronous reset.
package flash_cmd_pkg;

    // ========================================
    // Command codes and word indices
    localparam logic [7:0] cmd_sector_erase_c = 8'h0a;
    localparam logic [7:0] cmd_unsecure_c = 8'h0b;
    localparam logic [7:0] cmd_backdoor_c = 8'h0c;
    localparam logic [2:0] idx_sector_erase_c = 3'h1;
    localparam logic [2:0] idx_unsecure_c = 3'h0;
    localparam logic [2:0] idx_backdoor_c = 3'h4;

    // ========================================
    // Address field positions
    localparam int addr_region_lsb_c = 16;
    localparam int addr_region_msb_c = 22;
    localparam logic [2:0] phrase_align_c = 3'h0;
    localparam int sector_lsb_c = 10;
    localparam int sector_w_c = 8;

    // ========================================
    // Security and key enable encoding
    localparam logic [1:0] key_enabled_c = 2'h2;
    localparam logic [1:0] sec_unsecured_c = 2'h2;
    localparam logic [1:0] sec_secured_c = 2'h3;

    // ========================================
    // Reset values and timing
    localparam logic [1:0] sec_reset_c = 2'h3;
    localparam int clk_mhz_c = 20;
    localparam int erase_time_us_c = 4;
    localparam int erase_cycles_c = erase_time_us_c * clk_mhz_c;
    localparam logic [7:0] erase_cycles_w_c = 8'(erase_cycles_c);

    // ========================================
    // Grouped carriers
    typedef struct packed {
        logic [7:0] cmd;
        logic [2:0] index;
        logic [22:0] addr;
        logic [63:0] key;
    } command_object_words_t;

    typedef struct packed {
        logic access_error_flag;
        logic protection_violation_flag;
        logic verify_error_status;
        logic verify_fatal_status;
        logic command_complete_flag;
    } flash_status_register_t;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_check = 3'b001,
        st_erase = 3'b011,
        st_verify = 3'b010,
        st_key = 3'b111,
        st_done = 3'b110
    } seq_state_t;

endpackage : flash_cmd_pkg

/* src/launch_checker.sv */
// Launch-time error checks for one command object.
// Assumes inputs are steady in the cycle the check is taken.
`timescale 1ns/1ps
module launch_checker
    import flash_cmd_pkg::*;
(
    // Command
    input wire command_object_words_t words,
    input wire logic mode_allows_erase,
    input wire logic mode_allows_unsecure,
    // Region and protection
    input wire logic [127:0] region_valid,
    input wire logic [255:0] sector_protected,
    input wire logic any_protected,
    // Result
    output logic access_error,
    output logic protect_error
);
    logic [6:0] region;
    logic [7:0] sector;

    assign region = words.addr[addr_region_msb_c:addr_region_lsb_c];
    assign sector = words.addr[sector_lsb_c +: sector_w_c];

    always_comb begin
        access_error = 1'b0;
        protect_error = 1'b0;
        unique case (words.cmd)
            cmd_sector_erase_c: begin
                if (words.index != idx_sector_erase_c) access_error = 1'b1;
                if (!mode_allows_erase) access_error = 1'b1;
                if (!region_valid[region]) access_error = 1'b1;
                if (words.addr[2:0] != phrase_align_c) access_error = 1'b1;
                protect_error = sector_protected[sector];
            end
            cmd_unsecure_c: begin
                if (words.index != idx_unsecure_c) access_error = 1'b1;
                if (!mode_allows_unsecure) access_error = 1'b1;
                protect_error = any_protected;
            end
            cmd_backdoor_c: begin
                if (words.index != idx_backdoor_c) access_error = 1'b1;
            end
            default: access_error = 1'b1;
        endcase
    end
endmodule : launch_checker

/* src/erase_timer.sv */
// Countdown used to pace the erase phase.
// Assumes start is a single-cycle pulse.
`timescale 1ns/1ps
module erase_timer
    import flash_cmd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic start,
    output logic done
);
    logic [7:0] count_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_q <= 8'h00;
        end else if (start) begin
            count_q <= erase_cycles_w_c;
        end else if (count_q != 8'h00) begin
            count_q <= count_q - 8'h01;
        end
    end

    assign done = (count_q == 8'h01);
endmodule : erase_timer

/* src/flash_command_error_unsecure.sv */
// Flash command sequencer: launch checks, sector erase, array unsecure, backdoor key.
// Assumes the array model answers verify results and the CPU side decodes its own writes.
//
// Function
// - Sector erase needs final word index one
// - Command unavailable in mode sets access error
// - Invalid region address bits set access error
// - Misaligned phrase address sets access error
// - Protected sector erase sets protection violation
// - Any verify error sets verify error bit
// - Fatal verify error sets fatal bit
// - Unsecure is code 0x0b, index zero
// - Unsecure launch erases and verifies whole array
// - Verify pass makes device unsecured
// - Verify fail flags error, keeps security
// - Command complete sets when unsecure ends
// - Unsecure needs word index zero
// - Any protected region blocks unsecure
// - Backdoor verify runs only when keys enabled
// - Matching backdoor keys unsecure the device
`timescale 1ns/1ps
module flash_command_error_unsecure
    import flash_cmd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Command object and launch
    input wire command_object_words_t command_object_words,
    input wire logic launch,
    input wire logic clear_errors,
    // Mode and protection
    input wire logic mode_allows_erase,
    input wire logic mode_allows_unsecure,
    input wire logic [127:0] region_valid,
    input wire logic [255:0] sector_protected,
    input wire logic any_protected,
    // Security configuration
    input wire logic [1:0] backdoor_key_enable,
    input wire logic [63:0] stored_key,
    // Array interface
    output logic array_erase_all,
    output logic sector_erase,
    output logic [22:0] erase_addr,
    input wire logic verify_error,
    input wire logic verify_fatal,
    // Status
    output flash_status_register_t flash_status_register,
    output logic [1:0] security_state
);
    seq_state_t state_q;
    seq_state_t state_d;
    command_object_words_t cmd_q;
    logic acc_err;
    logic prot_err;
    logic timer_start;
    logic timer_done;
    logic access_error_q;
    logic protect_q;
    logic verr_q;
    logic vfatal_q;
    logic [1:0] sec_q;
    logic launch_ok;
    logic command_complete_seen;

    launch_checker launch_checker_inst (
        .words(command_object_words),
        .mode_allows_erase(mode_allows_erase),
        .mode_allows_unsecure(mode_allows_unsecure),
        .region_valid(region_valid),
        .sector_protected(sector_protected),
        .any_protected(any_protected),
        .access_error(acc_err),
        .protect_error(prot_err)
    );

    erase_timer erase_timer_inst (
        .core_clk(core_clk),
        .rst(rst),
        .start(timer_start),
        .done(timer_done)
    );

    // ========================================
    // Sequencer
    // A launch while busy is ignored; software must wait for the complete flag.
    assign launch_ok = launch && (state_q == st_idle) && !acc_err && !prot_err;

    always_comb begin
        state_d = state_q;
        timer_start = 1'b0;
        unique case (state_q)
            st_idle: begin
                if (launch_ok) begin
                    state_d = st_check;
                end
            end
            st_check: begin
                if (cmd_q.cmd == cmd_backdoor_c) begin
                    state_d = st_key;
                end else begin
                    state_d = st_erase;
                    timer_start = 1'b1;
                end
            end
            st_erase: begin
                if (timer_done) begin
                    state_d = st_verify;
                end
            end
            st_verify: state_d = st_done;
            st_key: state_d = st_done;
            st_done: state_d = st_idle;
            default: state_d = st_idle;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmd_q <= '0;
        end else if (launch && state_q == st_idle) begin
            cmd_q <= command_object_words;
        end
    end

    // ========================================
    // Error flags: a new error wins over a clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            access_error_q <= 1'b0;
            protect_q <= 1'b0;
        end else begin
            if (launch && state_q == st_idle && acc_err) begin
                access_error_q <= 1'b1;
            end else if (clear_errors) begin
                access_error_q <= 1'b0;
            end
            if (launch && state_q == st_idle && prot_err) begin
                protect_q <= 1'b1;
            end else if (clear_errors) begin
                protect_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            verr_q <= 1'b0;
            vfatal_q <= 1'b0;
        end else if (launch_ok) begin
            verr_q <= 1'b0;
            vfatal_q <= 1'b0;
        end else if (state_q == st_verify) begin
            verr_q <= verify_error | verify_fatal;
            vfatal_q <= verify_fatal;
        end
    end

    // ========================================
    // Security state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sec_q <= sec_reset_c;
        end else if (state_q == st_verify && cmd_q.cmd == cmd_unsecure_c) begin
            if (!verify_error && !verify_fatal) begin
                sec_q <= sec_unsecured_c;
            end
        end else if (state_q == st_key && backdoor_key_enable == key_enabled_c) begin
            if (cmd_q.key == stored_key) begin
                sec_q <= sec_unsecured_c;
            end
        end
    end

    // ========================================
    // Outputs
    // Complete is low only while a command that passed its checks runs.
    assign array_erase_all = (state_q == st_erase) && (cmd_q.cmd == cmd_unsecure_c);
    assign sector_erase = (state_q == st_erase) && (cmd_q.cmd == cmd_sector_erase_c);
    assign erase_addr = cmd_q.addr;
    assign security_state = sec_q;
    assign command_complete_seen = flash_status_register.command_complete_flag;

    always_comb begin
        flash_status_register.access_error_flag = access_error_q;
        flash_status_register.protection_violation_flag = protect_q;
        flash_status_register.verify_error_status = verr_q;
        flash_status_register.verify_fatal_status = vfatal_q;
        flash_status_register.command_complete_flag = (state_q == st_idle);
    end

    // ========================================
    // Checks
    sequence launch_bad_s;
        launch && state_q == st_idle && (acc_err || prot_err);
    endsequence

    sequence unsec_pass_s;
        state_q == st_verify && cmd_q.cmd == cmd_unsecure_c && !verify_error && !verify_fatal;
    endsequence

    sequence sect_launch_s;
        launch && state_q == st_idle && command_object_words.cmd == cmd_sector_erase_c;
    endsequence

    sequence unsec_launch_s;
        launch_ok && command_object_words.cmd == cmd_unsecure_c;
    endsequence

    erase_index_a: assert property (@(posedge core_clk) disable iff (rst)
        launch && state_q == st_idle && command_object_words.cmd == cmd_sector_erase_c
        && command_object_words.index != idx_sector_erase_c |=> access_error_q)
        else $error("sector erase bad index not flagged");

    misalign_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        launch && state_q == st_idle && command_object_words.cmd == cmd_sector_erase_c
        && command_object_words.addr[2:0] != 3'h0 |=> access_error_q)
        else $error("misaligned phrase not flagged");

    abort_complete_a: assert property (@(posedge core_clk) disable iff (rst)
        launch_bad_s |=> state_q == st_idle && flash_status_register.command_complete_flag)
        else $error("errored launch did not complete at once");

    unsec_index_a: assert property (@(posedge core_clk) disable iff (rst)
        launch && state_q == st_idle && command_object_words.cmd == cmd_unsecure_c
        && command_object_words.index != 3'h0 |=> access_error_q && state_q == st_idle)
        else $error("unsecure bad index not flagged");

    unsec_protect_a: assert property (@(posedge core_clk) disable iff (rst)
        launch && state_q == st_idle && command_object_words.cmd == cmd_unsecure_c
        && any_protected |=> protect_q)
        else $error("protected unsecure not flagged");

    unsec_release_a: assert property (@(posedge core_clk) disable iff (rst)
        unsec_pass_s |=> sec_q == sec_unsecured_c)
        else $error("unsecure pass did not release security");

    verify_fail_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == st_verify && cmd_q.cmd == cmd_unsecure_c && verify_error
        |=> verr_q && sec_q == $past(sec_q))
        else $error("verify fail handling wrong");

    fatal_bit_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == st_verify && verify_fatal |=> vfatal_q && verr_q)
        else $error("fatal verify bit not set");

    unsec_done_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == st_erase && cmd_q.cmd == cmd_unsecure_c |-> ##[1:90] command_complete_seen)
        else $error("unsecure did not complete in time");

    key_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == st_key && backdoor_key_enable != key_enabled_c
        |=> sec_q == $past(sec_q))
        else $error("backdoor ran while keys disabled");

    mode_erase_a: assert property (@(posedge core_clk) disable iff (rst)
        sect_launch_s ##0 !mode_allows_erase |=> access_error_q)
        else $error("sector erase in wrong mode not flagged");

    mode_unsec_a: assert property (@(posedge core_clk) disable iff (rst)
        launch && state_q == st_idle && command_object_words.cmd == cmd_unsecure_c
        && !mode_allows_unsecure |=> access_error_q)
        else $error("unsecure in wrong mode not flagged");

    region_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        sect_launch_s
        ##0 !region_valid[command_object_words.addr[addr_region_msb_c:addr_region_lsb_c]]
        |=> access_error_q)
        else $error("invalid region not flagged");

    sector_protect_a: assert property (@(posedge core_clk) disable iff (rst)
        sect_launch_s ##0 sector_protected[command_object_words.addr[sector_lsb_c +: sector_w_c]]
        |=> protect_q)
        else $error("protected sector not flagged");

    verify_any_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == st_verify && verify_error |=> verr_q)
        else $error("verify error bit not set");

    verify_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        launch_ok |=> !verr_q && !vfatal_q)
        else $error("verify bits not cleared at launch");

    fatal_only_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == st_verify && !verify_fatal |=> !vfatal_q)
        else $error("fatal verify bit set without cause");

    unsec_erase_a: assert property (@(posedge core_clk) disable iff (rst)
        unsec_launch_s |=> !command_complete_seen ##1 array_erase_all)
        else $error("unsecure launch did not start array erase");

    key_release_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == st_key && backdoor_key_enable == key_enabled_c
        && cmd_q.key == stored_key |=> sec_q == sec_unsecured_c)
        else $error("matching keys did not release security");

    key_mismatch_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == st_key && cmd_q.key != stored_key
        |=> sec_q == $past(sec_q))
        else $error("wrong keys changed security");

    abort_no_erase_a: assert property (@(posedge core_clk) disable iff (rst)
        launch_bad_s |=> !array_erase_all && !sector_erase
        ##1 !array_erase_all && !sector_erase)
        else $error("errored launch started an erase");
endmodule : flash_command_error_unsecure

/* tb/tb_flash_command_error_unsecure.sv */
// Self-checking bench for the flash command sequencer: launch checks, erase, unsecure, key.
// Assumes the design package is compiled first and its assertions run alongside.
`timescale 1ns/1ps
module tb_flash_command_error_unsecure;
    import flash_cmd_pkg::*;

    // ========================================
    // Expected outcome of one command
    typedef struct packed {
        logic [4:0] st;
        logic [4:0] mask;
        logic [1:0] sec;
        logic all_seen;
        logic sect_seen;
        logic [22:0] addr;
    } exp_t;

    // ========================================
    // Signals
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    command_object_words_t command_object_words = '0;
    logic launch = 1'b0;
    logic clear_errors = 1'b0;
    logic mode_allows_erase = 1'b1;
    logic mode_allows_unsecure = 1'b1;
    logic [127:0] region_valid = '1;
    logic [255:0] sector_protected = '0;
    logic any_protected = 1'b0;
    logic [1:0] backdoor_key_enable = 2'h0;
    logic [63:0] stored_key = '0;
    logic array_erase_all;
    logic sector_erase;
    logic [22:0] erase_addr;
    logic verify_error = 1'b0;
    logic verify_fatal = 1'b0;
    flash_status_register_t flash_status_register;
    logic [1:0] security_state;
    logic [4:0] st_bits;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int seed = int'(32'ha27f3171);
    exp_t exp_q[$];
    exp_t e;
    logic check_req = 1'b0;
    logic all_seen = 1'b0;
    logic sect_seen = 1'b0;
    logic [22:0] a;
    logic [63:0] k;

    assign st_bits = flash_status_register;

    always #25 core_clk = ~core_clk;

    flash_command_error_unsecure flash_command_error_unsecure_inst (
        .core_clk(core_clk),
        .rst(rst),
        .command_object_words(command_object_words),
        .launch(launch),
        .clear_errors(clear_errors),
        .mode_allows_erase(mode_allows_erase),
        .mode_allows_unsecure(mode_allows_unsecure),
        .region_valid(region_valid),
        .sector_protected(sector_protected),
        .any_protected(any_protected),
        .backdoor_key_enable(backdoor_key_enable),
        .stored_key(stored_key),
        .array_erase_all(array_erase_all),
        .sector_erase(sector_erase),
        .erase_addr(erase_addr),
        .verify_error(verify_error),
        .verify_fatal(verify_fatal),
        .flash_status_register(flash_status_register),
        .security_state(security_state)
    );

    // ========================================
    // Verdict
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // A hung sequencer would otherwise stall the run forever
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            $display("Error at %0t: timeout", $time);
            finish_test();
        end
    end

    // ========================================
    // Monitor: compares the oldest note when the driver flags a result
    always @(posedge core_clk) begin
        if (check_req && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            checked++;
            if (((st_bits ^ e.st) & e.mask) !== 5'h00 || security_state !== e.sec ||
                {all_seen, sect_seen} !== {e.all_seen, e.sect_seen} ||
                erase_addr !== e.addr) begin
                num_errors++;
                $display("Error at %0t: status %b security %h erase %b%b addr %h", $time,
                         st_bits, security_state, all_seen, sect_seen, erase_addr);
            end
        end
    end

    // ========================================
    // Driver
    task automatic do_reset();
        @(negedge core_clk) rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
    endtask : do_reset

    // Clears old error flags, launches, waits for completion, notes the expectation
    task automatic issue(input logic [7:0] cmd, input logic [2:0] idx, input logic [22:0] addr,
                         input logic [63:0] key, input logic [4:0] st, input logic [4:0] mask,
                         input logic [1:0] sec, input logic ea, input logic se);
        int n;
        @(negedge core_clk) clear_errors = 1'b1;
        @(negedge core_clk) begin
            clear_errors = 1'b0;
            command_object_words = '{cmd, idx, addr, key};
            launch = 1'b1;
            all_seen = 1'b0;
            sect_seen = 1'b0;
        end
        @(negedge core_clk) launch = 1'b0;
        for (n = 0; n < 200; n++) begin
            @(negedge core_clk);
            all_seen = all_seen | array_erase_all;
            sect_seen = sect_seen | sector_erase;
            if (n > 2 && flash_status_register.command_complete_flag === 1'b1) break;
        end
        if (n == 200) begin
            num_errors++;
            $display("Error at %0t: command never completed", $time);
        end
        exp_q.push_back('{st, mask, sec, ea, se, addr});
        check_req = 1'b1;
        @(negedge core_clk) check_req = 1'b0;
        $display("Test done: command %h index %h", cmd, idx);
    endtask : issue

    // ========================================
    // Main sequence
    initial begin
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        a = 23'($random(seed)) & 23'h7ffff8;
        k = {$random(seed), $random(seed)};
        // Launch-time refusals; verify bits still clear since nothing ran yet
        issue(cmd_sector_erase_c, 3'h2, a, k, 5'h11, 5'h1f, 2'h3, 0, 0);
        issue(cmd_sector_erase_c, 3'h0, a, k, 5'h11, 5'h1f, 2'h3, 0, 0);
        mode_allows_erase = 1'b0;
        issue(cmd_sector_erase_c, 3'h1, a, k, 5'h11, 5'h1f, 2'h3, 0, 0);
        mode_allows_erase = 1'b1;
        mode_allows_unsecure = 1'b0;
        issue(cmd_unsecure_c, 3'h0, a, k, 5'h11, 5'h1f, 2'h3, 0, 0);
        mode_allows_unsecure = 1'b1;
        region_valid[a[22:16]] = 1'b0;
        issue(cmd_sector_erase_c, 3'h1, a, k, 5'h11, 5'h1f, 2'h3, 0, 0);
        region_valid = '1;
        issue(cmd_sector_erase_c, 3'h1, a | 23'h4, k, 5'h11, 5'h1f, 2'h3, 0, 0);
        sector_protected[a[17:10]] = 1'b1;
        issue(cmd_sector_erase_c, 3'h1, a, k, 5'h09, 5'h1f, 2'h3, 0, 0);
        sector_protected = '0;
        issue(cmd_unsecure_c, 3'h1, a, k, 5'h11, 5'h1f, 2'h3, 0, 0);
        any_protected = 1'b1;
        issue(cmd_unsecure_c, 3'h0, a, k, 5'h09, 5'h1f, 2'h3, 0, 0);
        any_protected = 1'b0;
        // Verify failures: fatal alone must also raise the general bit
        verify_fatal = 1'b1;
        issue(cmd_sector_erase_c, 3'h1, a, k, 5'h07, 5'h1f, 2'h3, 0, 1);
        verify_fatal = 1'b0;
        verify_error = 1'b1;
        issue(cmd_unsecure_c, 3'h0, a, k, 5'h05, 5'h1f, 2'h3, 1, 0);
        verify_error = 1'b0;
        // Refused launches keep the verify bit; a good launch clears it
        stored_key = k;
        backdoor_key_enable = 2'h0;
        issue(cmd_backdoor_c, 3'h0, a, k, 5'h15, 5'h1f, 2'h3, 0, 0);
        issue(8'h3c, 3'h0, a, k, 5'h15, 5'h1f, 2'h3, 0, 0);
        issue(cmd_backdoor_c, 3'h4, a, k, 5'h01, 5'h1f, 2'h3, 0, 0);
        backdoor_key_enable = key_enabled_c;
        issue(cmd_backdoor_c, 3'h4, a, ~k, 5'h01, 5'h1f, 2'h3, 0, 0);
        issue(cmd_backdoor_c, 3'h4, a, k, 5'h01, 5'h1f, 2'h2, 0, 0);
        // Fresh secured device, then a clean unsecure
        do_reset();
        issue(cmd_unsecure_c, 3'h0, a, k, 5'h01, 5'h1f, 2'h2, 1, 0);
        repeat (3) @(negedge core_clk);
        finish_test();
    end

endmodule : tb_flash_command_error_unsecure
